//--- ssq_analog.sv
/*
  Stand-in for the analog output stages: follows the voltage setpoints
  only while the outputs are enabled. Assumes setpoints arrive on aclk.
*/
`timescale 1ns/10ps
`default_nettype none
module ssq_analog (
  input wire logic aclk,                                          // System clock
  input wire logic out_on,                                        // Outputs enabled
  input wire logic [ssq_pkg::NOUT*ssq_pkg::VAL_W-1:0] set_v,      // Voltage setpoints
  output logic [ssq_pkg::NOUT*ssq_pkg::VAL_W-1:0] drv_v           // Terminal voltages
);
  import ssq_pkg::*;
  // A disabled stage removes power, so no stale setpoint shows
  always_ff @(posedge aclk) begin
    drv_v <= out_on ? set_v : '0;
  end
endmodule : ssq_analog
`default_nettype wire

//--- ssq_mem.sv
/*
  Fifty-entry settings memory held in flip-flops.
  Assumes one write port and one registered read port on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
module ssq_mem (
  input wire logic aclk,                         // System clock
  input wire logic aresetn,                      // Synchronous reset
  input wire logic we,                           // Store entry
  input wire logic [ssq_pkg::LOC_W-1:0] waddr,   // Store location
  input wire logic [ssq_pkg::ENT_W-1:0] wdata,   // Entry to store
  input wire logic [ssq_pkg::LOC_W-1:0] raddr,   // Recall location
  output logic [ssq_pkg::ENT_W-1:0] rdata        // Entry, one cycle later
);
  import ssq_pkg::*;
  logic [ENT_W-1:0] ent [LOC_N];

  // Whole entry written at once, so all outputs change together
  for (genvar e = 0; e < LOC_N; e++) begin : g_ent
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        ent[e] <= '0;
      end else if (we && waddr == LOC_W'(e)) begin
        ent[e] <= wdata;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdata <= '0;
    end else begin
      rdata <= ent[raddr];
    end
  end

  store_back_a: assert property (@(posedge aclk) disable iff (!aresetn)
    we && raddr == waddr ##1 raddr == $past(waddr) |=> rdata == $past(wdata, 2))
    else $error("stored entry not read back whole");
endmodule : ssq_mem
`default_nettype wire

//--- ssq_pkg.sv
/*
  Constants, types and helpers shared by the settings store sequencer.
  Assumes a 40 MHz system clock and a 32-bit AXI4-Lite register bus.
*/
`default_nettype none
package ssq_pkg;
  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int NOUT = 3;
  localparam int NKIND = 3;
  localparam int LOC_N = 50;
  localparam int LOC_W = 6;
  localparam int VAL_W = 16;
  localparam int DLY_LSB = NKIND * NOUT * VAL_W;
  localparam int ENT_W = DLY_LSB + VAL_W;
  localparam int K_V = 0;
  localparam int K_OVP = 1;
  localparam int K_I = 2;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_CMD = 8'h04;
  localparam logic [7:0] A_STAT = 8'h08;
  localparam logic [7:0] A_DLY = 8'h0C;
  localparam logic [1:0] G_CTL = 2'h0;
  localparam int CTRL_TOG = 0;
  localparam int CTRL_AUTO = 1;
  localparam int CTRL_NEXT = 2;
  localparam int CTRL_BACK = 3;
  localparam int CMD_FIRST = 0;
  localparam int CMD_LAST = 8;
  localparam int CMD_OP = 16;
  localparam int ST_OUT = 0;
  localparam int ST_AUTO = 1;
  localparam int ST_ARM = 2;
  localparam int ST_ELOC = 3;
  localparam int ST_EDLY = 4;
  localparam int ST_RNG = 5;
  localparam int ST_LOC = 8;
  localparam int ST_FIRST = 16;
  localparam int ST_LAST = 24;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {OP_NONE, OP_STORE, OP_RECALL, OP_RANGE} ssq_op_t;
  // ----------------------------------------
  // Resolution and timing
  // ----------------------------------------
  localparam logic [VAL_W-1:0] V_FINE = 16'h000A;
  localparam logic [VAL_W-1:0] V_COARSE = 16'h0014;
  localparam logic [VAL_W-1:0] I_FINE = 16'h0001;
  localparam logic [VAL_W-1:0] I_COARSE = 16'h0002;
  localparam logic [VAL_W-1:0] DLY_MIN = 16'h0001;
  localparam logic [VAL_W-1:0] DLY_RST = 16'h0001;
  localparam int CLK_HZ = 40_000_000;
  localparam int TICK_S = 1;
  localparam int TICK_CYCLES = TICK_S * CLK_HZ;

  function automatic logic [VAL_W-1:0] ssq_quant(logic [VAL_W-1:0] val, logic [VAL_W-1:0] step);
    return val - (val % step);
  endfunction : ssq_quant
endpackage : ssq_pkg
`default_nettype wire

//--- ssq_tick.sv
/*
  One-second tick divider for step delays.
  Assumes clr is a same-clock pulse from the sequencer.
*/
`timescale 1ns/10ps
`default_nettype none
module ssq_tick #(
  parameter int TICK_CYCLES = ssq_pkg::TICK_CYCLES
) (
  input wire logic aclk,    // System clock
  input wire logic aresetn, // Synchronous reset
  input wire logic clr,     // Restart the second
  output logic tick         // One-cycle pulse per second
);
  import ssq_pkg::*;
  localparam int CW = $clog2(TICK_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);
  logic [CW-1:0] cnt;

  always_ff @(posedge aclk) begin
    if (!aresetn || clr || cnt == LAST) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + 1'b1;
    end
  end
  assign tick = aresetn && !clr && cnt == LAST;

  tick_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    clr |=> !tick && cnt == '0) else $error("tick not restarted by clear");
endmodule : ssq_tick
`default_nettype wire

//--- ssq_top.sv
/*
  Settings store sequencer: output enable, settings memory, recall,
  manual stepping and looping automatic sequence, behind AXI4-Lite.
  Assumes a single 40 MHz clock; analog stages take the setpoints as-is.
*/
// Register access over AXI4-Lite and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module ssq_top #(
  parameter int TICK_CYCLES = ssq_pkg::TICK_CYCLES,
  parameter logic [ssq_pkg::NOUT-1:0] V_HI = '0, // Outputs rated above 36 V
  parameter logic [ssq_pkg::NOUT-1:0] I_HI = '0  // Outputs rated above 3.5 A
) (
  input wire logic aclk,            // System clock
  input wire logic aresetn,         // Synchronous reset
  input wire logic awvalid,         // Write address valid
  output logic awready,             // Write address ready
  input wire logic [7:0] awaddr,    // Write address
  input wire logic [2:0] awprot,    // Unused
  input wire logic wvalid,          // Write data valid
  output logic wready,              // Write data ready
  input wire logic [31:0] wdata,    // Write data
  input wire logic [3:0] wstrb,     // Byte enables
  output logic bvalid,              // Write response valid
  input wire logic bready,          // Write response ready
  output logic [1:0] bresp,         // Write response
  input wire logic arvalid,         // Read address valid
  output logic arready,             // Read address ready
  input wire logic [7:0] araddr,    // Read address
  input wire logic [2:0] arprot,    // Unused
  output logic rvalid,              // Read data valid
  input wire logic rready,          // Read data ready
  output logic [31:0] rdata,        // Read data
  output logic [1:0] rresp,         // Read response
  output logic out_on,              // All outputs enabled, and its indicator
  output logic auto_on,             // Auto-run indicator
  output logic [ssq_pkg::NOUT*ssq_pkg::VAL_W-1:0] set_v,   // Voltage setpoints, mV
  output logic [ssq_pkg::NOUT*ssq_pkg::VAL_W-1:0] set_ovp, // Overvoltage setpoints, mV
  output logic [ssq_pkg::NOUT*ssq_pkg::VAL_W-1:0] set_i    // Current setpoints, mA
);
  import ssq_pkg::*;
  typedef enum logic [1:0] {SQ_IDLE, SQ_FETCH, SQ_HOLD} ssq_state_t;

  logic aw_held, w_held, wr_fire, wr_ok, rd_ok;
  logic [3:0] wstrb_q;
  logic [7:0] aw_addr;
  logic [31:0] w_data, wmask, wd;
  logic [VAL_W-1:0] act [NKIND][NOUT];
  logic [VAL_W-1:0] dly, dly_left, old;
  logic [LOC_W-1:0] cur_loc, rng_first, rng_last, fetch_addr, f_loc, l_loc;
  logic [ENT_W-1:0] ent_w, ent_r;
  logic armed, rng_ok, err_loc, err_dly, fetch_req, fetch_pend, tick, tick_clr;
  logic is_cmd, tog, key_auto, key_next, key_back, loc_bad, mem_we, seq_step, seq_start;
  ssq_op_t op;
  ssq_state_t state;

  // ----------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------
  assign awready = !aw_held && !bvalid;
  assign wready = !w_held && !bvalid;
  assign wr_fire = aw_held && w_held && !bvalid;
  assign wr_ok = aw_addr[7:6] == 2'h0 && (aw_addr[5:4] == G_CTL || aw_addr[3:2] != 2'h3);
  for (genvar b = 0; b < 4; b++) begin : g_mask
    assign wmask[8*b +: 8] = {8{wstrb_q[b]}};
  end
  assign wd = w_data & wmask;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      wstrb_q <= '0;
      bvalid <= 1'b0;
      bresp <= RESP_OK;
    end else begin
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        aw_addr <= awaddr;
      end
      if (wvalid && wready) begin
        w_held <= 1'b1;
        w_data <= wdata;
        wstrb_q <= wstrb;
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wr_ok ? RESP_OK : RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------
  assign arready = !rvalid;
  assign rd_ok = araddr[7:6] == 2'h0 && (araddr[5:4] == G_CTL || araddr[3:2] != 2'h3);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OK;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp <= rd_ok ? RESP_OK : RESP_SLVERR;
      rdata <= '0;
      if (!rd_ok) begin
        rdata <= '0;
      end else if (araddr[5:4] != G_CTL) begin
        rdata <= 32'(act[araddr[5:4] - 2'h1][araddr[3:2]]);
      end else if (araddr[3:0] == A_STAT[3:0]) begin
        rdata[ST_OUT] <= out_on;
        rdata[ST_AUTO] <= auto_on;
        rdata[ST_ARM] <= armed;
        rdata[ST_ELOC] <= err_loc;
        rdata[ST_EDLY] <= err_dly;
        rdata[ST_RNG] <= rng_ok;
        rdata[ST_LOC +: LOC_W] <= cur_loc;
        rdata[ST_FIRST +: LOC_W] <= rng_first;
        rdata[ST_LAST +: LOC_W] <= rng_last;
      end else if (araddr[3:0] == A_DLY[3:0]) begin
        rdata <= 32'(dly);
      end
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  assign tog = wr_fire && aw_addr == A_CTRL && wd[CTRL_TOG];
  assign key_auto = wr_fire && aw_addr == A_CTRL && wd[CTRL_AUTO];
  assign key_next = wr_fire && aw_addr == A_CTRL && wd[CTRL_NEXT];
  assign key_back = wr_fire && aw_addr == A_CTRL && wd[CTRL_BACK];
  assign is_cmd = wr_fire && aw_addr == A_CMD;
  assign op = ssq_op_t'(wd[CMD_OP +: 2]);
  assign f_loc = wd[CMD_FIRST +: LOC_W];
  assign l_loc = wd[CMD_LAST +: LOC_W];
  // Out-of-range locations and reversed ranges are refused outright
  assign loc_bad = is_cmd && op != OP_NONE && (wd[CMD_FIRST +: 8] >= 8'(LOC_N) ||
    (op == OP_RANGE && (wd[CMD_LAST +: 8] >= 8'(LOC_N) || l_loc < f_loc)));
  assign mem_we = is_cmd && op == OP_STORE && !loc_bad;

  // Entry image of the active settings for every output
  for (genvar k = 0; k < NKIND; k++) begin : g_kind
    for (genvar o = 0; o < NOUT; o++) begin : g_out
      assign ent_w[(k*NOUT+o)*VAL_W +: VAL_W] = act[k][o];
    end
  end
  assign ent_w[DLY_LSB +: VAL_W] = dly;
  for (genvar o = 0; o < NOUT; o++) begin : g_set
    assign set_v[o*VAL_W +: VAL_W] = act[K_V][o];
    assign set_ovp[o*VAL_W +: VAL_W] = act[K_OVP][o];
    assign set_i[o*VAL_W +: VAL_W] = act[K_I][o];
  end

  ssq_mem u_mem (
    .aclk(aclk),
    .aresetn(aresetn),
    .we(mem_we),
    .waddr(f_loc),
    .wdata(ent_w),
    .raddr(fetch_addr),
    .rdata(ent_r)
  );

  // ----------------------------------------
  // Fetch selection
  // ----------------------------------------
  // Sequencer wins; manual recall is ignored while auto-run owns the outputs
  always_comb begin
    fetch_req = 1'b0;
    fetch_addr = cur_loc;
    if (seq_step) begin
      fetch_req = 1'b1;
      fetch_addr = (cur_loc >= rng_last) ? rng_first : cur_loc + 1'b1;
    end else if (seq_start) begin
      fetch_req = 1'b1;
      fetch_addr = rng_first;
    end else if (auto_on) begin
      fetch_req = 1'b0;
    end else if (is_cmd && op == OP_RECALL && !loc_bad) begin
      fetch_req = 1'b1;
      fetch_addr = f_loc;
    end else if (key_next && rng_ok && cur_loc < rng_last) begin
      fetch_req = 1'b1;
      fetch_addr = cur_loc + 1'b1;
    end else if (key_back && rng_ok && cur_loc > rng_first) begin
      fetch_req = 1'b1;
      fetch_addr = cur_loc - 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fetch_pend <= 1'b0;
      cur_loc <= '0;
      rng_first <= '0;
      rng_last <= '0;
      rng_ok <= 1'b0;
    end else begin
      fetch_pend <= fetch_req;
      if (fetch_req) begin
        cur_loc <= fetch_addr;
      end
      if (is_cmd && op == OP_RANGE && !loc_bad && !auto_on) begin
        rng_first <= f_loc;
        rng_last <= l_loc;
        rng_ok <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Active settings
  // ----------------------------------------
  assign old = act[aw_addr[5:4] - 2'h1][aw_addr[3:2]];

  for (genvar k = 0; k < NKIND; k++) begin : g_act
    for (genvar o = 0; o < NOUT; o++) begin : g_act_o
      logic [VAL_W-1:0] step, nv;
      // Recalled values were quantised when they were first written
      assign step = (k == K_I) ? (I_HI[o] ? I_COARSE : I_FINE)
                               : (V_HI[o] ? V_COARSE : V_FINE);
      assign nv = VAL_W'((32'(old) & ~wmask) | wd);
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          act[k][o] <= '0;
        end else if (fetch_pend) begin
          act[k][o] <= ent_r[(k*NOUT+o)*VAL_W +: VAL_W];
        end else if (wr_fire && wr_ok && aw_addr[5:4] == 2'(k + 1) && aw_addr[3:2] == 2'(o)) begin
          act[k][o] <= ssq_quant(nv, step);
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dly <= DLY_RST;
      err_dly <= 1'b0;
      err_loc <= 1'b0;
    end else begin
      if (fetch_pend) begin
        dly <= ent_r[DLY_LSB +: VAL_W];
      end else if (wr_fire && aw_addr == A_DLY && VAL_W'(wd) >= DLY_MIN) begin
        dly <= VAL_W'(wd);
      end
      // New error beats a same-cycle clear
      if (wr_fire && aw_addr == A_DLY && VAL_W'(wd) < DLY_MIN) begin
        err_dly <= 1'b1;
      end else if (wr_fire && aw_addr == A_STAT && wd[ST_EDLY]) begin
        err_dly <= 1'b0;
      end
      if (loc_bad) begin
        err_loc <= 1'b1;
      end else if (wr_fire && aw_addr == A_STAT && wd[ST_ELOC]) begin
        err_loc <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Output enable and automatic sequence
  // ----------------------------------------
  assign tick_clr = fetch_pend && auto_on;
  assign seq_step = state == SQ_HOLD && tick && dly_left <= DLY_MIN;

  ssq_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
    .aclk(aclk),
    .aresetn(aresetn),
    .clr(tick_clr),
    .tick(tick)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_on <= 1'b0;
      auto_on <= 1'b0;
      armed <= 1'b0;
      state <= SQ_IDLE;
      dly_left <= DLY_RST;
    end else begin
      if (key_auto && !out_on) begin
        armed <= 1'b1;
      end
      if (tog) begin
        out_on <= !out_on;
        armed <= 1'b0;
      end
      case (state)
        SQ_IDLE: begin
          if (seq_start) begin
            auto_on <= 1'b1;
            state <= SQ_FETCH;
          end
        end
        SQ_FETCH: begin
          if (fetch_pend) begin
            // A zero entry was never stored with a delay; hold it one second
            dly_left <= (ent_r[DLY_LSB +: VAL_W] < DLY_MIN) ? DLY_MIN : ent_r[DLY_LSB +: VAL_W];
            state <= SQ_HOLD;
          end
        end
        SQ_HOLD: begin
          if (seq_step) begin
            state <= SQ_FETCH;
          end else if (tick) begin
            dly_left <= dly_left - 1'b1;
          end
        end
        default: state <= SQ_IDLE;
      endcase
      if (tog && out_on) begin
        auto_on <= 1'b0;
        state <= SQ_IDLE;
      end
    end
  end

  // Leaving idle fetches the first entry, else the fetch state waits forever
  assign seq_start = state == SQ_IDLE && tog && !out_on && armed && rng_ok;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  out_enable_a: assert property (@(posedge aclk) disable iff (!aresetn)
    tog && !out_on |=> out_on) else $error("toggle did not enable outputs");
  out_disable_a: assert property (@(posedge aclk) disable iff (!aresetn)
    tog && out_on |=> !out_on) else $error("toggle did not disable outputs");
  loc_range_a: assert property (@(posedge aclk) disable iff (!aresetn)
    mem_we |-> f_loc < LOC_W'(LOC_N)) else $error("store beyond location 49");
  recall_apply_a: assert property (@(posedge aclk) disable iff (!aresetn)
    fetch_req |=> fetch_pend ##1 set_v == $past(ent_r[NOUT*VAL_W-1:0])) else $error("recall not applied");
  range_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    is_cmd && op == OP_RANGE && !loc_bad && !auto_on |=> rng_ok && rng_first <= rng_last)
    else $error("range not taken");
  step_next_a: assert property (@(posedge aclk) disable iff (!aresetn)
    key_next && !seq_step && !auto_on && rng_ok && cur_loc < rng_last |=> cur_loc == $past(cur_loc) + 1'b1)
    else $error("advance key did not step forward");
  delay_reject_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire && aw_addr == A_DLY && VAL_W'(wd) == '0 |=> err_dly && dly != '0) else $error("zero delay accepted");
  auto_loop_a: assert property (@(posedge aclk) disable iff (!aresetn)
    seq_step && cur_loc == rng_last |=> cur_loc == rng_first) else $error("sequence did not loop");
  auto_leds_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state != SQ_IDLE |-> auto_on && out_on) else $error("indicators wrong while running");
  auto_stop_a: assert property (@(posedge aclk) disable iff (!aresetn)
    tog && out_on |=> !auto_on && state == SQ_IDLE) else $error("sequence kept running");
endmodule : ssq_top
`default_nettype wire

//--- tb.sv
/*
  Self-checking bench for the settings store sequencer over AXI4-Lite.
  Assumes a 40 MHz clock and a shortened one-second tick of 20 cycles.
*/
`timescale 1ns/10ps
`default_nettype none
module tb;
  import ssq_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic bready = 1'b0, rready = 1'b0;
  logic [3:0] wstrb = 4'hF;
  logic [31:0] wdata = 32'h0, rdata, seed = 32'hC25C30F0;
  logic awready, wready, bvalid, arready, rvalid, out_on, auto_on;
  logic [1:0] bresp, rresp;
  logic [47:0] set_v, set_ovp, set_i, drv_v;
  logic [33:0] exp_q[$];
  logic [31:0] msk_q[$];
  string nm_q[$];
  int bad_count = 0;
  int compares = 0;
  always #12.5 aclk = ~aclk;

  ssq_top #(.TICK_CYCLES(20), .V_HI(3'b010), .I_HI(3'b100)) DUT (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp), .out_on(out_on), .auto_on(auto_on), .set_v(set_v), .set_ovp(set_ovp),
    .set_i(set_i));
  ssq_analog stage (.aclk(aclk), .out_on(out_on), .set_v(set_v), .drv_v(drv_v));

  // ----------------------------------------
  // Checking
  // ----------------------------------------
  task automatic chk(input string nm, input logic [33:0] got, input logic [33:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic end_of_test();
    $display("Compares %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test

  // Oldest note is matched against each read beat as it lands
  always @(posedge aclk) begin
    if (rvalid === 1'b1) chk(nm_q.pop_front(), {rresp, rdata & msk_q.pop_front()}, exp_q.pop_front());
  end

  // ----------------------------------------
  // Bus master
  // ----------------------------------------
  function automatic logic [31:0] lfsr();
    seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04C11DB7 : 32'h0);
    return seed;
  endfunction : lfsr

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OK,
                    input logic [3:0] s = 4'hF);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (aw || w) begin
      @(posedge aclk);
      if (aw && awready) begin aw = 1'b0; awvalid <= 1'b0; end
      if (w && wready) begin w = 1'b0; wvalid <= 1'b0; end
    end
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", {32'h0, bresp}, {32'h0, er});
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                    input logic [1:0] er = RESP_OK);
    exp_q.push_back({er, e & m});
    msk_q.push_back(m);
    nm_q.push_back($sformatf("reg_%h", a));
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask : rd

  initial begin
    #(25 * 20000);
    bad_count++;
    end_of_test();
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    logic [15:0] v;
    int n;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(A_STAT, 32'h0, 32'hFFFFFFFF);
    rd(A_DLY, 32'h1, 32'hFFFF);
    rd(8'h1C, 32'h0, 32'hFFFFFFFF, RESP_SLVERR);
    wr(8'h40, 32'h5, RESP_SLVERR);
    for (int o = 0; o < 3; o++) begin
      v = 16'(lfsr() >> 16);
      wr(8'(16 + 4 * o), {16'h0, v});
      rd(8'(16 + 4 * o), 32'(v - v % (o == 1 ? 20 : 10)), 32'hFFFF);
      wr(8'(32 + 4 * o), {16'h0, v});
      rd(8'(32 + 4 * o), 32'(v - v % (o == 1 ? 20 : 10)), 32'hFFFF);
      wr(8'(48 + 4 * o), {16'h0, v});
      rd(8'(48 + 4 * o), 32'(v - v % (o == 2 ? 2 : 1)), 32'hFFFF);
    end
    wr(A_DLY, 32'h0);
    rd(A_DLY, 32'h1, 32'hFFFF);
    rd(A_STAT, 32'h10, 32'h10);
    wr(A_DLY, 32'hFFFF);
    rd(A_DLY, 32'hFFFF, 32'hFFFF);
    wr(A_DLY, 32'h1);
    wr(8'h10, 32'h03E8);
    wr(8'h24, 32'h0FA0);
    wr(8'h38, 32'hFFFF_0064, RESP_OK, 4'h3);
    wr(A_CMD, 32'h0001_0001);
    wr(8'h10, 32'h07D0);
    wr(8'h24, 32'h0);
    wr(A_DLY, 32'h2);
    wr(A_CMD, 32'h0001_0002);
    wr(A_CMD, 32'h0002_0001);
    rd(8'h10, 32'h03E8, 32'hFFFF);
    rd(8'h24, 32'h0FA0, 32'hFFFF);
    rd(8'h38, 32'h0064, 32'hFFFF);
    rd(A_DLY, 32'h1, 32'hFFFF);
    wr(A_CMD, 32'h0001_0031);
    wr(A_CMD, 32'h0002_0031);
    rd(A_STAT, 32'h3110, 32'h3F18);
    wr(A_CMD, 32'h0002_0032);
    rd(A_STAT, 32'h3108, 32'h3F08);
    wr(A_STAT, 32'h18);
    wr(A_CMD, 32'h0003_0201);
    rd(A_STAT, 32'h0201_0020, 32'h3F3F_0038);
    wr(A_CMD, 32'h0002_0001);
    for (int k = 0; k < 4; k++) begin
      wr(A_CTRL, k < 2 ? 32'h4 : 32'h8);
      rd(8'h10, k < 2 ? 32'h07D0 : 32'h03E8, 32'hFFFF);
    end
    wr(A_CMD, 32'h0001_0001);
    wr(A_CTRL, 32'h1);
    rd(A_STAT, 32'h1, 32'h3);
    chk("drv_v", {18'h0, drv_v[15:0]}, 34'h03E8);
    wr(A_CTRL, 32'h1);
    rd(A_STAT, 32'h0, 32'h3);
    chk("drv_v", {18'h0, drv_v[15:0]}, 34'h0);
    wr(A_CTRL, 32'h2);
    rd(A_STAT, 32'h4, 32'h7);
    wr(A_CTRL, 32'h1);
    rd(A_STAT, 32'h3, 32'h3);
    n = 0;
    while (set_v[15:0] !== 16'h07D0 && n < 200) begin @(posedge aclk); n++; end
    n = 0;
    while (set_v[15:0] === 16'h07D0 && n < 200) begin @(posedge aclk); n++; end
    // Two seconds of 20 cycles plus fetch latency
    chk("hold", {33'h0, n >= 39 && n <= 44}, 34'h1);
    chk("wrap", {18'h0, set_v[15:0]}, 34'h03E8);
    wr(A_CTRL, 32'h1);
    rd(A_STAT, 32'h0, 32'h3);
    end_of_test();
  end
endmodule : tb
`default_nettype wire
